// file: verilog/csra_host.sv
// Host controller that runs access cycles on a strobe-clocked static RAM.
//
// Operation
// - Reads keep the write strobe high through the whole cycle.
// - Address changes only after address hold time from select falling.
// - Select stays low between minimum width and 10000 ns.
// - Select stays high for precharge; full cycle meets minimum period.
// - Write strobe falls with valid data, lead time before select rises.
// - Write data holds past both select and write strobe falling edges.
// - Write strobe pulse width and hold from select are honoured.
// - Read-modify-write reads, waits a modify span, writes, meets minimum.
// - After power returns, select stays high for standby recovery.
// - Any active cycle finishes before power-down begins.
// - After power-up both strobes stay high at least 2 ms.
module csra_host
    import csra_pkg::*;
#(
    parameter int POWER_UP_CYC = CSRA_POWER_UP_CYC, // Power-up wait.
    parameter int RECOVER_CYC = CSRA_RECOVER_CYC, // Standby recovery.
    parameter int LOW_MAX_CYC = CSRA_LOW_MAX_CYC // Longest strobe low.
) (
    input wire logic clock_i, // System clock, 100 MHz.
    input wire logic resetn_i, // Asynchronous reset, active low.
    input wire csra_req_s req_i, // Access request from the user.
    input wire logic [CSRA_CNT_W-1:0] modify_cyc_i, // Read-modify span.
    input wire logic pd_req_i, // Level: ask to enter power-down.
    input wire logic rdata_i, // Data output pin of the RAM.
    output logic req_ready_o, // High when a request is taken.
    output csra_rsp_s rsp_o, // Read data, one-cycle valid pulse.
    output csra_pins_s pins_o, // Strobes, address and write data.
    output logic pd_ack_o // High while the RAM may be powered down.
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        csra_state_e st;
        csra_op_e op;
        logic wdata;
        logic [CSRA_CNT_W-1:0] mod_cyc;
        logic ready;
        csra_rsp_s rsp;
        csra_pins_s pins;
        logic pd_ack;
    } csra_host_s;

    csra_host_s s_q;
    csra_host_s s_d;
    logic tmr_clear;
    logic [CSRA_CNT_W-1:0] tmr;
    logic [CSRA_CNT_W-1:0] we_tmr;
    logic we_clear;

    csra_timer u_cyc_timer (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .clear_i(tmr_clear),
        .count_o(tmr)
    );

    csra_timer u_we_timer (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .clear_i(we_clear),
        .count_o(we_tmr)
    );

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    // Cycle time in strobe-low cycles: the low phase for each operation.
    function automatic csra_cnt_t low_span(input csra_op_e op,
                                           input csra_cnt_t mcyc);
        csra_cnt_t base;
        base = csra_cnt_t'(CSRA_LOW_MIN_CYC);
        if (csra_cnt_t'(CSRA_CYCLE_CYC - CSRA_PRE_CYC) > base) begin
            base = csra_cnt_t'(CSRA_CYCLE_CYC - CSRA_PRE_CYC);
        end
        if (op == CSRA_OP_RMW || op == CSRA_OP_LATE_WRITE) begin
            base = csra_cnt_t'(CSRA_ACCESS_CYC + CSRA_LEAD_CYC) + mcyc;
            if (csra_cnt_t'(CSRA_RMW_CYC - CSRA_PRE_CYC) > base) begin
                base = csra_cnt_t'(CSRA_RMW_CYC - CSRA_PRE_CYC);
            end
        end
        if (base > csra_cnt_t'(LOW_MAX_CYC)) begin
            base = csra_cnt_t'(LOW_MAX_CYC);
        end
        return base;
    endfunction

    always_comb begin
        s_d = s_q;
        tmr_clear = 1'b0;
        we_clear = 1'b0;
        s_d.rsp.valid = 1'b0;
        s_d.ready = 1'b0;
        case (s_q.st)
            CSRA_ST_POWER_UP: begin
                if (tmr >= csra_cnt_t'(POWER_UP_CYC)) begin
                    s_d.st = CSRA_ST_IDLE;
                    tmr_clear = 1'b1;
                end
            end
            CSRA_ST_IDLE: begin
                if (pd_req_i && tmr >= csra_cnt_t'(CSRA_PPD_CYC)) begin
                    s_d.st = CSRA_ST_POWER_DOWN;
                    s_d.pd_ack = 1'b1;
                end else if (!pd_req_i && req_i.valid) begin
                    // Address settles with strobe fall; set-up time is zero.
                    s_d.st = CSRA_ST_ACTIVE;
                    s_d.op = req_i.op;
                    s_d.wdata = req_i.wdata;
                    s_d.mod_cyc = low_span(req_i.op, modify_cyc_i);
                    s_d.pins.addr = req_i.addr;
                    s_d.pins.wdata = req_i.wdata;
                    s_d.pins.cs_n = 1'b0;
                    s_d.pins.we_n = (req_i.op != CSRA_OP_EARLY_WRITE);
                    s_d.ready = 1'b1;
                    tmr_clear = 1'b1;
                    we_clear = 1'b1;
                end
            end
            CSRA_ST_ACTIVE: begin
                // Sample read data at access time, output is then valid.
                if (tmr == csra_cnt_t'(CSRA_ACCESS_CYC)
                    && s_q.op != CSRA_OP_EARLY_WRITE
                    && s_q.op != CSRA_OP_LATE_WRITE) begin
                    s_d.rsp.valid = 1'b1;
                    s_d.rsp.rdata = rdata_i;
                end
                // Late write strobe waits until access time so output is sane.
                // Two spare cycles let the data hold end with the low span.
                if (s_q.pins.we_n && s_q.op != CSRA_OP_READ
                    && tmr + csra_cnt_t'(CSRA_LEAD_CYC + 2) >= s_q.mod_cyc
                    && tmr >= csra_cnt_t'(CSRA_ACCESS_CYC)) begin
                    s_d.pins.we_n = 1'b0;
                    we_clear = 1'b1;
                end
                if (tmr + CSRA_CNT_ONE >= s_q.mod_cyc
                    && tmr >= csra_cnt_t'(CSRA_ADDR_HOLD_CYC)
                    && tmr >= csra_cnt_t'(CSRA_DHC_CYC)
                    && tmr >= csra_cnt_t'(CSRA_WHOLD_CYC)
                    && (s_q.pins.we_n || (we_tmr >= csra_cnt_t'(CSRA_DHW_CYC)
                    && we_tmr >= csra_cnt_t'(CSRA_WPULSE_CYC)))) begin
                    s_d.st = CSRA_ST_PRECHARGE;
                    s_d.pins.cs_n = 1'b1;
                    tmr_clear = 1'b1;
                end
            end
            CSRA_ST_PRECHARGE: begin
                s_d.pins.we_n = 1'b1;
                // Precharge also covers output release before the next cycle.
                if (tmr + CSRA_CNT_ONE >= csra_cnt_t'(CSRA_PRE_CYC)
                    && tmr + CSRA_CNT_ONE
                       >= csra_cnt_t'(CSRA_RELEASE_CYC)) begin
                    s_d.st = CSRA_ST_IDLE;
                end
            end
            CSRA_ST_POWER_DOWN: begin
                // Select held high for the whole standby period.
                if (!pd_req_i) begin
                    s_d.st = CSRA_ST_RECOVER;
                    tmr_clear = 1'b1;
                end
            end
            CSRA_ST_RECOVER: begin
                s_d.pd_ack = 1'b0;
                if (tmr >= csra_cnt_t'(RECOVER_CYC)) begin
                    s_d.st = CSRA_ST_IDLE;
                    tmr_clear = 1'b1;
                end
            end
            default: begin
                s_d.st = CSRA_ST_IDLE;
                s_d.pins.cs_n = 1'b1;
                s_d.pins.we_n = 1'b1;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q.st <= CSRA_ST_POWER_UP;
            s_q.op <= CSRA_OP_READ;
            s_q.wdata <= 1'b0;
            s_q.mod_cyc <= CSRA_CNT_ZERO;
            s_q.ready <= 1'b0;
            s_q.rsp <= '0;
            s_q.pins.cs_n <= 1'b1;
            s_q.pins.we_n <= 1'b1;
            s_q.pins.addr <= '0;
            s_q.pins.wdata <= 1'b0;
            s_q.pd_ack <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign req_ready_o = s_q.ready;
    assign rsp_o = s_q.rsp;
    assign pins_o = s_q.pins;
    assign pd_ack_o = s_q.pd_ack;

endmodule

// file: verilog/csra_pkg.sv
// Package of timing constants, types and states for the static RAM host.
package csra_pkg;

    // ----------------------------------------------------------------
    // Device geometry
    // ----------------------------------------------------------------
    localparam int CSRA_ADDR_W = 12;
    localparam int CSRA_DEPTH = 4096;

    // ----------------------------------------------------------------
    // Clock and timing figures (fastest grade, in ns unless noted)
    // ----------------------------------------------------------------
    localparam int CSRA_CLK_NS = 10;
    localparam int CSRA_ACCESS_TIME_NS = 200;
    localparam int CSRA_OUTPUT_RELEASE_NS = 50;
    localparam int CSRA_ADDRESS_HOLD_NS = 110;
    localparam int CSRA_STROBE_LOW_WIDTH_NS = 200;
    localparam int CSRA_STROBE_LOW_MAX_NS = 10000;
    localparam int CSRA_PRECHARGE_MIN_NS = 100;
    localparam int CSRA_CYCLE_PERIOD_MIN_NS = 310;
    localparam int CSRA_WRITE_LEAD_NS = 70;
    localparam int CSRA_DATA_HOLD_SELECT_NS = 170;
    localparam int CSRA_DATA_HOLD_WRITE_NS = 70;
    localparam int CSRA_WRITE_PULSE_NS = 60;
    localparam int CSRA_WRITE_HOLD_TIME_NS = 150;
    localparam int CSRA_RMW_CYCLE_MIN_NS = 385;
    localparam int CSRA_PRECHARGE_PD_NS = 100;
    localparam int CSRA_STANDBY_RECOVERY_US = 500;
    localparam int CSRA_POWER_UP_MS = 2;

    // Minimum times round up, maximum times round down.
    localparam int CSRA_ACCESS_CYC = CSRA_ACCESS_TIME_NS / CSRA_CLK_NS;
    localparam int CSRA_RELEASE_CYC =
        (CSRA_OUTPUT_RELEASE_NS + CSRA_CLK_NS - 1) / CSRA_CLK_NS;
    localparam int CSRA_ADDR_HOLD_CYC =
        (CSRA_ADDRESS_HOLD_NS + CSRA_CLK_NS - 1) / CSRA_CLK_NS;
    localparam int CSRA_LOW_MIN_CYC =
        (CSRA_STROBE_LOW_WIDTH_NS + CSRA_CLK_NS - 1) / CSRA_CLK_NS;
    localparam int CSRA_LOW_MAX_CYC = CSRA_STROBE_LOW_MAX_NS / CSRA_CLK_NS;
    localparam int CSRA_PRE_CYC =
        (CSRA_PRECHARGE_MIN_NS + CSRA_CLK_NS - 1) / CSRA_CLK_NS;
    localparam int CSRA_CYCLE_CYC =
        (CSRA_CYCLE_PERIOD_MIN_NS + CSRA_CLK_NS - 1) / CSRA_CLK_NS;
    localparam int CSRA_LEAD_CYC =
        (CSRA_WRITE_LEAD_NS + CSRA_CLK_NS - 1) / CSRA_CLK_NS;
    localparam int CSRA_DHC_CYC =
        (CSRA_DATA_HOLD_SELECT_NS + CSRA_CLK_NS - 1) / CSRA_CLK_NS;
    localparam int CSRA_DHW_CYC =
        (CSRA_DATA_HOLD_WRITE_NS + CSRA_CLK_NS - 1) / CSRA_CLK_NS;
    localparam int CSRA_WPULSE_CYC =
        (CSRA_WRITE_PULSE_NS + CSRA_CLK_NS - 1) / CSRA_CLK_NS;
    localparam int CSRA_WHOLD_CYC =
        (CSRA_WRITE_HOLD_TIME_NS + CSRA_CLK_NS - 1) / CSRA_CLK_NS;
    localparam int CSRA_RMW_CYC =
        (CSRA_RMW_CYCLE_MIN_NS + CSRA_CLK_NS - 1) / CSRA_CLK_NS;
    localparam int CSRA_PPD_CYC =
        (CSRA_PRECHARGE_PD_NS + CSRA_CLK_NS - 1) / CSRA_CLK_NS;
    localparam int CSRA_RECOVER_CYC =
        CSRA_STANDBY_RECOVERY_US * 1000 / CSRA_CLK_NS;
    localparam int CSRA_POWER_UP_CYC =
        CSRA_POWER_UP_MS * 1000000 / CSRA_CLK_NS;

    // ----------------------------------------------------------------
    // Counter width and types
    // ----------------------------------------------------------------
    localparam int CSRA_CNT_W = 24;
    typedef logic [CSRA_CNT_W-1:0] csra_cnt_t;
    typedef logic [CSRA_ADDR_W-1:0] csra_addr_t;

    typedef enum logic [1:0] {
        CSRA_OP_READ = 2'h0,
        CSRA_OP_EARLY_WRITE = 2'h1,
        CSRA_OP_LATE_WRITE = 2'h2,
        CSRA_OP_RMW = 2'h3
    } csra_op_e;

    typedef enum logic [2:0] {
        CSRA_ST_POWER_UP = 3'h0,
        CSRA_ST_IDLE = 3'h1,
        CSRA_ST_ACTIVE = 3'h2,
        CSRA_ST_MODIFY = 3'h3,
        CSRA_ST_PRECHARGE = 3'h4,
        CSRA_ST_POWER_DOWN = 3'h5,
        CSRA_ST_RECOVER = 3'h6
    } csra_state_e;

    typedef struct packed {
        logic valid;
        csra_op_e op;
        csra_addr_t addr;
        logic wdata;
    } csra_req_s;

    typedef struct packed {
        logic valid;
        logic rdata;
    } csra_rsp_s;

    typedef struct packed {
        logic cs_n;
        logic we_n;
        csra_addr_t addr;
        logic wdata;
    } csra_pins_s;

    // Counter-width zero and one for counter resets and increments.
    localparam csra_cnt_t CSRA_CNT_ZERO = '0;
    localparam csra_cnt_t CSRA_CNT_ONE = csra_cnt_t'(1);

endpackage

// file: verilog/csra_timer.sv
// Cycle counter that reports how many cycles have elapsed since its last clear.
module csra_timer
    import csra_pkg::*;
(
    input wire logic clock_i, // System clock.
    input wire logic resetn_i, // Asynchronous reset, active low.
    input wire logic clear_i, // Restart the count at zero.
    output logic [CSRA_CNT_W-1:0] count_o // Cycles since last clear.
);

    // ----------------------------------------------------------------
    // Saturating counter
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_o <= CSRA_CNT_ZERO;
        end else if (clear_i) begin
            count_o <= CSRA_CNT_ZERO;
        end else if (count_o != '1) begin
            count_o <= count_o + CSRA_CNT_ONE;
        end
    end

endmodule

// file: dv/csra_host_monitor.sv
// Checker of strobe timing at the static RAM host controller's ports.
module csra_host_monitor
    import csra_pkg::*;
#(
    parameter int POWER_UP_CYC = 20, // Power-up wait.
    parameter int RECOVER_CYC = 20, // Standby recovery.
    parameter int LOW_MAX_CYC = 1000 // Longest strobe low.
) (
    input wire logic clock_i, // Clock.
    input wire logic resetn_i, // Reset, active low.
    input wire csra_req_s req_i, // Request.
    input wire logic [CSRA_CNT_W-1:0] modify_cyc_i, // Modify span.
    input wire logic pd_req_i, // Power-down ask.
    input wire logic rdata_i, // RAM output.
    input wire logic req_ready_o, // Request taken.
    input wire csra_rsp_s rsp_o, // Read response.
    input wire csra_pins_s pins_o, // RAM pins.
    input wire logic pd_ack_o // Power-down granted.
);
    // ------------------------------------------------------------
    // Cycle counters
    // ------------------------------------------------------------
    csra_cnt_t low_q, high_q, cyc_q, we_q, up_q, rec_q;
    csra_op_e op_q, cur_op;
    assign cur_op = req_ready_o ? req_i.op : op_q;
    function automatic csra_cnt_t sat(input csra_cnt_t c);
        return c + csra_cnt_t'(c != '1);
    endfunction
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {low_q, high_q, we_q, up_q} <= '0;
            {cyc_q, rec_q} <= '1;
            op_q <= CSRA_OP_READ;
        end else begin
            low_q <= pins_o.cs_n ? '0 : sat(low_q);
            high_q <= pins_o.cs_n ? sat(high_q) : '0;
            we_q <= pins_o.we_n ? '0 : sat(we_q);
            cyc_q <= (!pins_o.cs_n && low_q == '0) ? CSRA_CNT_ONE : sat(cyc_q);
            up_q <= sat(up_q);
            rec_q <= pd_req_i ? '0 : sat(rec_q);
            op_q <= cur_op;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    sequence cs_fall_s; $fell(pins_o.cs_n); endsequence
    sequence cs_rise_s; $rose(pins_o.cs_n); endsequence
    low_width_a:
        assert property (cs_rise_s |-> low_q >= CSRA_LOW_MIN_CYC
            && low_q <= LOW_MAX_CYC) else $error("select low width off");
    precharge_a:
        assert property (cs_fall_s |-> high_q >= CSRA_PRE_CYC)
            else $error("precharge too short");
    cycle_time_a:
        assert property (cs_fall_s |-> cyc_q >= (op_q == CSRA_OP_RMW ?
            CSRA_RMW_CYC : CSRA_CYCLE_CYC)) else $error("cycle too short");
    read_we_a:
        assert property (!pins_o.cs_n && (cur_op == CSRA_OP_READ
            || cur_op != CSRA_OP_EARLY_WRITE && low_q < CSRA_ACCESS_CYC)
            |-> pins_o.we_n) else $error("write strobe low too soon");
    addr_hold_a:
        assert property (!pins_o.cs_n && low_q != '0
            && low_q < CSRA_ADDR_HOLD_CYC |-> $stable(pins_o.addr))
            else $error("address changed in hold time");
    data_hold_a:
        assert property ((!pins_o.cs_n && low_q != '0 && low_q < CSRA_DHC_CYC)
            || (!pins_o.we_n && we_q != '0 && we_q < CSRA_DHW_CYC)
            |-> $stable(pins_o.wdata)) else $error("write data not held");
    write_lead_a:
        assert property (cs_rise_s ##0 !$past(pins_o.we_n)
            |-> we_q >= CSRA_LEAD_CYC) else $error("write lead too short");
    write_pulse_a:
        assert property ($rose(pins_o.we_n) |-> we_q >= CSRA_WPULSE_CYC
            && cyc_q >= CSRA_WHOLD_CYC) else $error("write strobe too short");
    power_up_a:
        assert property (up_q < POWER_UP_CYC |-> pins_o.cs_n && pins_o.we_n)
            else $error("strobe low during power-up");
    pd_entry_a:
        assert property (pd_ack_o |-> pins_o.cs_n && high_q >= CSRA_PPD_CYC)
            else $error("power-down without precharge");
    recovery_a:
        assert property (cs_fall_s |-> rec_q >= RECOVER_CYC)
            else $error("cycle during standby recovery");
endmodule
bind csra_host csra_host_monitor #(.POWER_UP_CYC(POWER_UP_CYC),
    .RECOVER_CYC(RECOVER_CYC), .LOW_MAX_CYC(LOW_MAX_CYC)) mon (
    .clock_i(clock_i), .resetn_i(resetn_i), .req_i(req_i),
    .modify_cyc_i(modify_cyc_i), .pd_req_i(pd_req_i), .rdata_i(rdata_i),
    .req_ready_o(req_ready_o), .rsp_o(rsp_o), .pins_o(pins_o),
    .pd_ack_o(pd_ack_o));

// file: dv/csra_ram_model.sv
// Behavioural model of the strobe-clocked 4096 by 1 static RAM.
module csra_ram_model
    import csra_pkg::*;
#(
    parameter int ACC_CYC = 18 // Access delay in cycles.
) (
    input wire logic clock_i, // Clock for the access timer.
    input wire csra_pins_s pins_i, // Strobes, address and write data.
    output logic rdata_o // Data output pin.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic mem [CSRA_DEPTH];
    csra_addr_t addr_q = '0;
    logic early_q = 1'h0;
    logic rd_q = 1'h0;
    int low_q = 0;
    initial foreach (mem[i]) mem[i] = 1'h0;
    always @(negedge pins_i.cs_n) begin
        addr_q = pins_i.addr;
        early_q = !pins_i.we_n;
        if (early_q) mem[addr_q] = pins_i.wdata;
    end
    always @(negedge pins_i.we_n) begin
        if (!pins_i.cs_n && !early_q && low_q > 0) mem[addr_q] = pins_i.wdata;
    end
    always @(posedge clock_i) begin
        if (low_q == ACC_CYC - 1) rd_q <= mem[addr_q];
        low_q <= pins_i.cs_n ? 0 : low_q + 1;
    end
    // A floating output shows the inverse of the last value.
    assign rdata_o = (!pins_i.cs_n && !early_q && low_q >= ACC_CYC) ?
        rd_q : !rd_q;
endmodule

// file: dv/csra_host_tb.sv
// Self-checking bench for the static RAM host controller.
module csra_host_tb
    import csra_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        csra_op_e op;
        csra_addr_t addr;
        logic wdata;
        logic exp;
        csra_cnt_t mod;
    } csra_row_s;
    logic clock_i, resetn_i, pd_req_i, rdata_i, req_ready_o, pd_ack_o;
    csra_req_s req_i;
    csra_rsp_s rsp_o;
    csra_pins_s pins_o;
    csra_cnt_t modify_cyc_i;
    int n_mismatch = 0;
    int checks_done = 0;
    csra_row_s rows [8] = '{
        '{CSRA_OP_EARLY_WRITE, 12'h000, 1'h1, 1'h0, 24'h0},
        '{CSRA_OP_LATE_WRITE, 12'hfff, 1'h1, 1'h0, 24'h0},
        '{CSRA_OP_READ, 12'h000, 1'h0, 1'h1, 24'h0},
        '{CSRA_OP_RMW, 12'h555, 1'h1, 1'h0, 24'h400},
        '{CSRA_OP_READ, 12'h555, 1'h0, 1'h1, 24'h0},
        '{CSRA_OP_RMW, 12'hfff, 1'h0, 1'h1, 24'h0},
        '{CSRA_OP_READ, 12'hfff, 1'h0, 1'h0, 24'h0},
        '{CSRA_OP_READ, 12'haaa, 1'h0, 1'h0, 24'h0}};
    csra_host #(.POWER_UP_CYC(20), .RECOVER_CYC(20), .LOW_MAX_CYC(1000)) uut (
        .clock_i(clock_i), .resetn_i(resetn_i), .req_i(req_i),
        .modify_cyc_i(modify_cyc_i), .pd_req_i(pd_req_i), .rdata_i(rdata_i),
        .req_ready_o(req_ready_o), .rsp_o(rsp_o), .pins_o(pins_o),
        .pd_ack_o(pd_ack_o));
    csra_ram_model ram (.clock_i(clock_i), .pins_i(pins_o), .rdata_o(rdata_i));
    initial begin
        clock_i = 1'h0;
        forever #5 clock_i = ~clock_i;
    end
    task automatic chk(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %b", $time, what, got);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic run_op(input csra_row_s r);
        int n;
        @(posedge clock_i);
        req_i <= '{1'h1, r.op, r.addr, r.wdata};
        modify_cyc_i <= r.mod;
        n = 0;
        do begin
            @(negedge clock_i);
            n++;
        end while (req_ready_o !== 1'h1 && n < 2000);
        chk(req_ready_o, 1'h1, "request not taken");
        @(posedge clock_i);
        req_i.valid <= 1'h0;
        if (r.op == CSRA_OP_READ || r.op == CSRA_OP_RMW) begin
            n = 0;
            do begin
                @(negedge clock_i);
                n++;
            end while (rsp_o.valid !== 1'h1 && n < 100);
            chk(rsp_o.valid, 1'h1, "read response missing");
            chk(rsp_o.rdata, r.exp, "read data");
        end
    endtask
    initial begin
        #100us;
        n_mismatch++;
        $display("unexpected at %0t: watchdog expired", $time);
        stop_test();
    end
    // ------------------------------------------------------------
    // Table of cycles, then power-down and reset cases
    // ------------------------------------------------------------
    initial begin
        req_i = '0;
        modify_cyc_i = '0;
        pd_req_i = 1'h0;
        resetn_i = 1'h0;
        repeat (8) @(posedge clock_i);
        resetn_i <= 1'h1;
        foreach (rows[i]) run_op(rows[i]);
        @(posedge clock_i);
        pd_req_i <= 1'h1;
        req_i <= '{1'h1, CSRA_OP_READ, 12'hfff, 1'h0};
        repeat (40) begin
            @(negedge clock_i);
            chk(req_ready_o, 1'h0, "taken in power-down");
        end
        chk(pd_ack_o, 1'h1, "power-down not granted");
        chk(pins_o.cs_n, 1'h1, "select low in power-down");
        @(posedge clock_i);
        pd_req_i <= 1'h0;
        req_i.valid <= 1'h0;
        run_op('{CSRA_OP_READ, 12'h555, 1'h0, 1'h1, 24'h0});
        @(posedge clock_i);
        req_i <= '{1'h1, CSRA_OP_RMW, 12'h0ff, 1'h1};
        repeat (15) @(posedge clock_i);
        resetn_i <= 1'h0;
        req_i.valid <= 1'h0;
        @(negedge clock_i);
        chk(pins_o.cs_n, 1'h1, "select in reset");
        chk(pins_o.we_n, 1'h1, "write strobe in reset");
        chk(pd_ack_o, 1'h0, "power-down in reset");
        @(posedge clock_i);
        resetn_i <= 1'h1;
        run_op('{CSRA_OP_READ, 12'h000, 1'h0, 1'h1, 24'h0});
        stop_test();
    end
endmodule
